// File: swr_pkg.sv
`default_nettype none
// ==========================================================================
// shared timing, configuration bits and state codes
package swr_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    // times as printed, in their own units
    localparam int unsigned PWR_RST_US     = 1300;
    localparam int unsigned RST_PULSE_US   = 1;
    localparam int unsigned PWR_PD_US      = 1300;
    localparam int unsigned PD_PULSE_US    = 10;
    localparam int unsigned SLEEP_NS       = 50;
    localparam int unsigned WAKE_CLK_US    = 2000;
    localparam int unsigned STABLE_US      = 2100;
    localparam int unsigned WAKE_INT_US    = 2000;
    localparam int unsigned SPI_RDY_US     = 1;
    // least times round up, longest times round down, never below one
    localparam int unsigned PWR_RST_CYC    = PWR_RST_US * CLK_MHZ;
    localparam int unsigned RST_PULSE_CYC  = RST_PULSE_US * CLK_MHZ;
    localparam int unsigned PWR_PD_CYC     = PWR_PD_US * CLK_MHZ;
    localparam int unsigned PD_PULSE_CYC   = PD_PULSE_US * CLK_MHZ;
    localparam int unsigned SLEEP_CYC      =
        (SLEEP_NS / CLK_PERIOD_NS) < 1 ? 1 : SLEEP_NS / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CLK_CYC   = WAKE_CLK_US * CLK_MHZ;
    localparam int unsigned STABLE_CYC     = STABLE_US * CLK_MHZ;
    localparam int unsigned WAKE_INT_CYC   = WAKE_INT_US * CLK_MHZ;
    localparam int unsigned SPI_RDY_CYC    = SPI_RDY_US * CLK_MHZ;
    localparam int unsigned CNT_W          = 24;
    // configuration and wake-enable registers
    localparam logic [7:0]  CFG_ADDR       = 8'h05;
    localparam logic [7:0]  WAKE_EN_ADDR   = 8'h1c;
    localparam int unsigned CFG_POL_BIT    = 0;
    localparam int unsigned CFG_DRV_BIT    = 1;
    localparam int unsigned WAKE_EN_BIT    = 0;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  WAKE_EN_RESET  = 8'h00;

    typedef enum logic [2:0] {
        SWR_OFF    = 3'b000,
        SWR_SLEEP  = 3'b001,
        SWR_WAKING = 3'b010,
        SWR_CLKON  = 3'b011,
        SWR_READY  = 3'b100
    } swr_dev_state_t;

    typedef enum logic [2:0] {
        SWH_POWERUP = 3'b000,
        SWH_RUN     = 3'b001,
        SWH_SLEEP   = 3'b010,
        SWH_WAIT    = 3'b011,
        SWH_SETTLE  = 3'b100,
        SWH_RESET   = 3'b101
    } swr_host_state_t;
endpackage
`default_nettype wire

// File: swr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// link pins between host and device; irq is a device output with an output enable
interface swr_if;
    logic power_down_n;
    logic reset_n;
    logic osc_clock_output;
    logic irq_o;
    logic irq_oe;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_we;

    modport device (
        input  power_down_n, reset_n, reg_addr, reg_wdata, reg_we,
        output osc_clock_output, irq_o, irq_oe
    );
    modport host (
        output power_down_n, reset_n, reg_addr, reg_wdata, reg_we,
        input  osc_clock_output, irq_o, irq_oe
    );
endinterface
`default_nettype wire

// File: swr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// three-stage synchroniser; change accepted when stages two and three agree
module swr_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    input  wire logic d_in,
    output var  logic q_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            q_out <= INIT;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_out <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// File: swr_device.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Overview of operation
// - host holds reset 1300 us after power
// - every reset pulse lasts at least 1 us
// - power-down held 1300 us after power
// - power-down asserted while power comes up
// - power-down pulses last at least 10 us
// - device sleeps within 50 ns of power-down; here low power rises 10 cycles (100 ns) after the pin falls
// - clock output resumes 2000 us after wake
// - oscillator stable 2100 us after wake
// - host waits 1 us after stable
// - wake event raises irq if enabled
// - wake interrupt 2000 us after wake
// - irq polarity and drive set by 0x05
module swr_device
    import swr_pkg::*;
#(
    parameter int unsigned SLEEP_CYCLES  = SLEEP_CYC,
    parameter int unsigned WAKE_CYCLES   = WAKE_CLK_CYC,
    parameter int unsigned STABLE_CYCLES = STABLE_CYC,
    parameter int unsigned IRQ_CYCLES    = WAKE_INT_CYC
) (
    input  wire logic   sys_clk_in,
    input  wire logic   rstn_in,
    input  wire logic   clk_out_en_in,
    input  wire logic   irq_clear_in,
    swr_if.device       link,
    output var  logic   low_power_out,
    output var  logic   osc_stable_out,
    output var  logic   wake_pending_out,
    output var  logic [2:0] state_out
);
    // ======================================================================
    // pin synchronisers
    logic pd_n_s;
    logic rst_n_s;

    swr_sync #(.INIT(1'b0)) u_pd_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (link.power_down_n),
        .q_out      (pd_n_s)
    );
    swr_sync #(.INIT(1'b0)) u_rst_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (link.reset_n),
        .q_out      (rst_n_s)
    );

    // ======================================================================
    // configuration registers, written over the host strobe
    logic [7:0] cfg_q;
    logic [7:0] wake_en_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_q     <= CFG_RESET;
            wake_en_q <= WAKE_EN_RESET;
        end else if (!rst_n_s) begin
            cfg_q     <= CFG_RESET;
            wake_en_q <= WAKE_EN_RESET;
        end else if (link.reg_we && link.reg_addr == CFG_ADDR) begin
            cfg_q <= link.reg_wdata;
        end else if (link.reg_we && link.reg_addr == WAKE_EN_ADDR) begin
            wake_en_q <= link.reg_wdata;
        end
    end

    // ======================================================================
    // sleep / wake sequencer
    swr_dev_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] sleep_cnt_q;
    logic             pd_n_prev_q;

    function automatic logic reached(input logic [CNT_W-1:0] c,
                                     input int unsigned lim);
        return c >= CNT_W'(lim - 1);
    endfunction

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pd_n_prev_q <= 1'b0;
        end else begin
            pd_n_prev_q <= pd_n_s;
        end
    end

    // power-down wins at once; sleep entry pays only the sync delay
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= SWR_OFF;
            cnt_q   <= '0;
        end else if (!pd_n_s) begin
            state_q <= SWR_SLEEP;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                SWR_OFF, SWR_SLEEP: begin
                    state_q <= SWR_WAKING;
                    cnt_q   <= '0;
                end
                SWR_WAKING: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, WAKE_CYCLES)) begin
                        state_q <= SWR_CLKON;
                    end
                end
                SWR_CLKON: begin
                    // count runs on from the release: stable is timed from it
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, STABLE_CYCLES)) begin
                        state_q <= SWR_READY;
                    end
                end
                SWR_READY: begin
                    cnt_q <= cnt_q;
                end
                default: begin
                    state_q <= SWR_OFF;
                end
            endcase
        end
    end

    // low-power flag follows the sleep state within the allotted cycles
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sleep_cnt_q   <= '0;
            low_power_out <= 1'b1;
        end else if (state_q == SWR_SLEEP || state_q == SWR_OFF) begin
            if (reached(sleep_cnt_q, SLEEP_CYCLES)) begin
                low_power_out <= 1'b1;
            end else begin
                sleep_cnt_q <= sleep_cnt_q + 1'b1;
            end
        end else begin
            sleep_cnt_q   <= '0;
            low_power_out <= 1'b0;
        end
    end

    // ======================================================================
    // wake interrupt: timed from the release, set wins over clear
    logic [CNT_W-1:0] irq_cnt_q;
    logic             irq_timing_q;
    logic             wake_set;

    assign wake_set = irq_timing_q && reached(irq_cnt_q, IRQ_CYCLES);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_timing_q <= 1'b0;
            irq_cnt_q    <= '0;
        end else if (!pd_n_s) begin
            irq_timing_q <= 1'b0;
            irq_cnt_q    <= '0;
        end else if (pd_n_s && !pd_n_prev_q) begin
            irq_timing_q <= 1'b1;
            irq_cnt_q    <= '0;
        end else if (wake_set) begin
            irq_timing_q <= 1'b0;
        end else if (irq_timing_q) begin
            irq_cnt_q <= irq_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_pending_out <= 1'b0;
        end else if (wake_set && wake_en_q[WAKE_EN_BIT]) begin
            wake_pending_out <= 1'b1;
        end else if (irq_clear_in || !pd_n_s) begin
            wake_pending_out <= 1'b0;
        end
    end

    // ======================================================================
    // pin outputs
    logic irq_active;
    logic osc_run;

    assign irq_active = wake_pending_out;
    // pol bit set: active high; drive bit set: open drain (drive active only)
    assign link.irq_o = cfg_q[CFG_POL_BIT] ? irq_active : !irq_active;
    assign link.irq_oe = cfg_q[CFG_DRV_BIT] ? irq_active : 1'b1;

    assign osc_run = (state_q == SWR_CLKON) || (state_q == SWR_READY);

    // clock output is a gated enable, not a real clock in this model
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.osc_clock_output <= 1'b0;
            osc_stable_out        <= 1'b0;
        end else begin
            link.osc_clock_output <= osc_run && clk_out_en_in;
            osc_stable_out        <= state_q == SWR_READY;
        end
    end

    assign state_out = state_q;
endmodule
`default_nettype wire

// File: swr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host end: drives power-down and reset with the required hold times
module swr_host
    import swr_pkg::*;
#(
    parameter int unsigned POWERUP_CYCLES = PWR_PD_CYC,
    parameter int unsigned RST_CYCLES     = RST_PULSE_CYC,
    parameter int unsigned PD_CYCLES      = PD_PULSE_CYC,
    parameter int unsigned STABLE_CYCLES  = STABLE_CYC,
    parameter int unsigned SPI_CYCLES     = SPI_RDY_CYC
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       sleep_req_in,
    input  wire logic       reset_req_in,
    input  wire logic       wr_req_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    swr_if.host             link,
    output var  logic       ready_out,
    output var  logic [2:0] state_out
);
    swr_host_state_t state_q;
    logic [CNT_W-1:0] cnt_q;

    function automatic logic reached(input logic [CNT_W-1:0] c,
                                     input int unsigned lim);
        return c >= CNT_W'(lim - 1);
    endfunction

    // both pins held low from power-up; one counter covers every hold
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q           <= SWH_POWERUP;
            cnt_q             <= '0;
            link.power_down_n <= 1'b0;
            link.reset_n      <= 1'b0;
        end else begin
            unique case (state_q)
                SWH_POWERUP: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, POWERUP_CYCLES)) begin
                        link.reset_n      <= 1'b1;
                        link.power_down_n <= 1'b1;
                        state_q           <= SWH_SETTLE;
                        cnt_q             <= '0;
                    end
                end
                SWH_SETTLE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, STABLE_CYCLES + SPI_CYCLES)) begin
                        state_q <= SWH_RUN;
                        cnt_q   <= '0;
                    end
                end
                SWH_RUN: begin
                    if (reset_req_in) begin
                        link.reset_n <= 1'b0;
                        state_q      <= SWH_RESET;
                    end else if (sleep_req_in) begin
                        link.power_down_n <= 1'b0;
                        state_q           <= SWH_SLEEP;
                    end
                end
                SWH_RESET: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, RST_CYCLES)) begin
                        link.reset_n <= 1'b1;
                        state_q      <= SWH_WAIT;
                        cnt_q        <= '0;
                    end
                end
                SWH_SLEEP: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (reached(cnt_q, PD_CYCLES) && !sleep_req_in) begin
                        link.power_down_n <= 1'b1;
                        state_q           <= SWH_SETTLE;
                        cnt_q             <= '0;
                    end
                end
                SWH_WAIT: begin
                    cnt_q   <= '0;
                    state_q <= SWH_RUN;
                end
                default: begin
                    state_q <= SWH_POWERUP;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.reg_we    <= 1'b0;
            link.reg_addr  <= 8'h00;
            link.reg_wdata <= 8'h00;
        end else begin
            link.reg_we <= wr_req_in && state_q == SWH_RUN;
            if (wr_req_in && state_q == SWH_RUN) begin
                link.reg_addr  <= wr_addr_in;
                link.reg_wdata <= wr_data_in;
            end
        end
    end

    assign ready_out = state_q == SWH_RUN;
    assign state_out = state_q;
endmodule
`default_nettype wire

// File: swr_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// link checker, sees the pins between host and device plus the clock-out enable
module swr_properties
    import swr_pkg::*;
#(
    parameter int PWRUP   = 150,
    parameter int RST_MIN = 20,
    parameter int PD_MIN  = 10,
    parameter int WAKE    = 50,
    parameter int IRQ     = 50
) (
    input wire logic       sys_clk_in,
    input wire logic       rstn_in,
    input wire logic       clk_out_en_in,
    input wire logic       power_down_n,
    input wire logic       reset_n,
    input wire logic       osc_clock_output,
    input wire logic       irq_o,
    input wire logic       irq_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we
);
    localparam int W_LO = WAKE;
    localparam int W_HI = WAKE + 10;
    localparam int I_LO = IRQ;
    localparam int I_HI = IRQ + 10;
    int         pd_lo_q;
    int         rs_lo_q;
    logic       pd_up_q;
    logic       rs_up_q;
    logic       wen_q;
    logic [1:0] cfg_q;
    logic [3:0] age_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // ======================================================================
    // low-time counters of both host pins
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pd_lo_q <= 0;
            rs_lo_q <= 0;
            pd_up_q <= 1'b0;
            rs_up_q <= 1'b0;
        end else begin
            pd_lo_q <= power_down_n ? 0 : pd_lo_q + 1;
            rs_lo_q <= reset_n ? 0 : rs_lo_q + 1;
            pd_up_q <= pd_up_q | power_down_n;
            rs_up_q <= rs_up_q | reset_n;
        end
    end

    // ======================================================================
    // shadow of irq setup; age keeps checks off while a write lands
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_q <= 2'h0;
            wen_q <= 1'b0;
            age_q <= 4'h0;
        end else if (!reset_n) begin
            cfg_q <= 2'h0;
            wen_q <= 1'b0;
            age_q <= 4'h0;
        end else if (reg_we) begin
            if (reg_addr == CFG_ADDR) cfg_q <= reg_wdata[1:0];
            if (reg_addr == WAKE_EN_ADDR) wen_q <= reg_wdata[0];
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end

    // ======================================================================
    // properties
    property p_pwr_rst;
        $rose(reset_n) && !rs_up_q |-> rs_lo_q >= PWRUP;
    endproperty
    property p_rst_pulse;
        $rose(reset_n) |-> rs_lo_q >= RST_MIN;
    endproperty
    property p_pwr_pd;
        $rose(power_down_n) && !pd_up_q |-> pd_lo_q >= PWRUP;
    endproperty
    property p_pd_reset;
        $rose(rstn_in) |-> !power_down_n && !reset_n;
    endproperty
    property p_pd_pulse;
        $rose(power_down_n) |-> pd_lo_q >= PD_MIN;
    endproperty
    property p_sleep;
        $fell(power_down_n) |-> ##[1:12] !osc_clock_output;
    endproperty
    property p_clk_wake;
        $rose(power_down_n) && clk_out_en_in
            |-> ##[W_LO:W_HI] osc_clock_output;
    endproperty
    property p_wake_irq;
        $rose(power_down_n) && wen_q
            |-> ##[I_LO:I_HI] (irq_oe && irq_o == cfg_q[0]);
    endproperty
    property p_irq_drive;
        age_q > 4'h5
            |-> (cfg_q[1] ? (!irq_oe || irq_o == cfg_q[0]) : irq_oe);
    endproperty

    a_pwr_rst: assert property (p_pwr_rst)
        else $error("reset released too soon after power-up");
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset pulse too short");
    a_pwr_pd: assert property (p_pwr_pd)
        else $error("power-down released too soon after power-up");
    a_pd_reset: assert property (p_pd_reset)
        else $error("power-down not asserted at power-up");
    a_pd_pulse: assert property (p_pd_pulse)
        else $error("power-down pulse too short");
    a_sleep: assert property (p_sleep)
        else $error("clock output still running after power-down");
    a_clk_wake: assert property (p_clk_wake)
        else $error("clock output not back in time after wake");
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake interrupt missing or late");
    a_irq_drive: assert property (p_irq_drive)
        else $error("irq pin drive does not match configuration");

    c_sleep: cover property ($fell(power_down_n));
    c_wake_irq: cover property ($rose(power_down_n) && wen_q);
    c_reset: cover property ($fell(reset_n) && rs_up_q);
endmodule
`default_nettype wire

// File: sleep_wake_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// both ends joined; bench drives host requests and device side inputs
module sleep_wake_reset_sequencer_tb_top;
    import swr_pkg::*;
    // shortened counts keep the run small
    localparam int WAKE  = 50;
    localparam int STB   = 60;
    localparam int IRQ   = 50;
    localparam int PWRUP = 150;
    localparam int RST   = 20;
    localparam int PDW   = 10;
    localparam int SPI   = 5;
    logic       sys_clk   = 1'b0;
    logic       rstn      = 1'b0;
    logic       clk_en    = 1'b1;
    logic       irq_clr   = 1'b0;
    logic       sleep_req = 1'b0;
    logic       reset_req = 1'b0;
    logic       wr_req    = 1'b0;
    logic [7:0] wr_addr   = 8'h00;
    logic [7:0] wr_data   = 8'h00;
    logic       pol       = 1'b0;
    logic       low_power;
    logic       osc_stable;
    logic       ready;
    logic       irq_pin;
    logic       pend;
    logic [2:0] dev_st;
    logic [2:0] host_st;
    int         errors    = 0;
    int         n_compared = 0;
    int         t_pd, t_clk, t_stb, t_irq, t_rdy;

    always #5 sys_clk = ~sys_clk;

    swr_if link_if ();
    // pull keeps a released irq line at its inactive level
    assign irq_pin = link_if.irq_oe ? link_if.irq_o : ~pol;

    swr_device #(.WAKE_CYCLES(WAKE), .STABLE_CYCLES(STB),
                 .IRQ_CYCLES(IRQ)) i_swr_device (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .clk_out_en_in(clk_en),
        .irq_clear_in(irq_clr), .link(link_if.device),
        .low_power_out(low_power), .osc_stable_out(osc_stable),
        .wake_pending_out(pend), .state_out(dev_st));
    swr_host #(.POWERUP_CYCLES(PWRUP), .RST_CYCLES(RST), .PD_CYCLES(PDW),
               .STABLE_CYCLES(WAKE + STB + 10),
               .SPI_CYCLES(SPI)) i_swr_host (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .sleep_req_in(sleep_req),
        .reset_req_in(reset_req), .wr_req_in(wr_req),
        .wr_addr_in(wr_addr), .wr_data_in(wr_data), .link(link_if.host),
        .ready_out(ready), .state_out(host_st));
    swr_properties #(.PWRUP(PWRUP), .RST_MIN(RST), .PD_MIN(PDW),
                     .WAKE(WAKE), .IRQ(IRQ)) u_props (
        .sys_clk_in(sys_clk), .rstn_in(rstn), .clk_out_en_in(clk_en),
        .power_down_n(link_if.power_down_n), .reset_n(link_if.reset_n),
        .osc_clock_output(link_if.osc_clock_output),
        .irq_o(link_if.irq_o), .irq_oe(link_if.irq_oe),
        .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
        .reg_we(link_if.reg_we));

    // ======================================================================
    // compare and access tasks
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v > hi) begin
            errors++;
            $display("[ERR] %0t count %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wr_req = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge sys_clk);
        wr_req = 1'b0;
    endtask

    // times of wake events, counted from the power-down release
    task automatic watch;
        int   t;
        logic lo;
        lo = 1'b0;
        t_pd = -1; t_clk = -1; t_stb = -1; t_irq = -1; t_rdy = -1;
        for (t = 0; t < 1000 && t_rdy < 0; t++) begin
            @(negedge sys_clk);
            if (t == 18) chk(low_power === 1'b1, "not in low power");
            if (t == 18) chk(link_if.osc_clock_output === 1'b0, "clk on");
            if (t == 18) chk(dev_st === SWR_SLEEP, "device awake");
            if (t == 19) sleep_req = 1'b0;
            if (link_if.power_down_n === 1'b0) lo = 1'b1;
            if (t_pd < 0 && lo && link_if.power_down_n === 1'b1) t_pd = t;
            if (t_pd >= 0) begin
                if (t_clk < 0 && link_if.osc_clock_output === 1'b1)
                    t_clk = t - t_pd;
                if (t_stb < 0 && osc_stable === 1'b1) t_stb = t - t_pd;
                if (t_irq < 0 && irq_pin === pol) t_irq = t - t_pd;
                if (t_rdy < 0 && ready === 1'b1) t_rdy = t - t_pd;
            end
        end
    endtask

    task automatic cycle(input logic [1:0] cfg, input logic wen,
                         input logic cen, input logic slp);
        if (slp) begin
            wr(CFG_ADDR, {6'h00, cfg});
            wr(WAKE_EN_ADDR, {7'h00, wen});
            pol = cfg[0];
            clk_en = cen;
            sleep_req = 1'b1;
        end
        watch();
        chk_rng(t_clk, cen ? WAKE : -1, cen ? WAKE + 10 : -1);
        chk_rng(t_stb, STB, STB + 10);
        chk_rng(t_irq, wen ? IRQ : -1, wen ? IRQ + 10 : -1);
        if (wen) chk_rng(t_stb - t_irq, 1, WAKE + STB);
        chk_rng(t_rdy - t_stb, SPI, 1000);
        chk(pend === wen, "wake pending wrong");
        if (wen) begin
            chk(irq_pin === pol, "wake interrupt dropped");
            @(negedge sys_clk);
            irq_clr = 1'b1;
            @(negedge sys_clk);
            irq_clr = 1'b0;
            repeat (3) @(negedge sys_clk);
            chk(irq_pin === ~pol, "interrupt not cleared");
        end
        chk(link_if.irq_oe === ~cfg[1], "idle irq drive wrong");
        $display("wake test cfg=%0d wen=%0d done", cfg, wen);
    endtask

    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin : main
        int i;
        int lo;
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        watch();
        // the first edge after release has passed when watch starts counting
        chk_rng(t_pd + 1, PWRUP, PWRUP + 10);
        chk(link_if.reset_n === 1'b1, "reset still held");
        chk_rng(t_stb, STB, STB + 10);
        chk_rng(t_rdy - t_stb, SPI, 1000);
        $display("power-up test done");
        for (i = 0; i < 5; i++)
            cycle(i < 4 ? i[1:0] : 2'h3, i < 4, i < 3, 1'b1);
        @(negedge sys_clk);
        reset_req = 1'b1;
        lo = 0;
        for (i = 0; i < 3000; i++) begin
            @(negedge sys_clk);
            reset_req = 1'b0;
            if (link_if.reset_n === 1'b0) lo++;
            if (lo == 1) chk(host_st === SWH_RESET, "no reset state");
            if (lo > 0 && link_if.reset_n === 1'b1 && ready === 1'b1) break;
        end
        pol = 1'b0;
        chk_rng(lo, RST, RST + 5);
        chk(ready === 1'b1, "host not ready after reset");
        chk(link_if.irq_oe === 1'b1, "irq drive not reset");
        chk(link_if.irq_o === 1'b1, "irq level not reset");
        $display("reset test done");
        report_and_stop();
    end

    initial begin : watchdog
        #100_000;
        errors++;
        $display("[ERR] %0t run did not finish", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
